//--- logic/ptm_pkg.sv
// Constants and types shared by the periodic timer module
package ptm_pkg;
  // ----------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------
  localparam int unsigned PTM_AW = 3;
  localparam int unsigned PTM_DW = 8;
  localparam int unsigned PTM_CW = 10;
  localparam int unsigned PTM_PW = 6;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] PTM_REG_CTRL0 = 3'h0;
  localparam logic [2:0] PTM_REG_CTRL1 = 3'h1;
  localparam logic [2:0] PTM_REG_CNTL = 3'h2;
  localparam logic [2:0] PTM_REG_CNTH = 3'h3;
  localparam logic [2:0] PTM_REG_CMPAL = 3'h4;
  localparam logic [2:0] PTM_REG_CMPAH = 3'h5;
  localparam logic [2:0] PTM_REG_PERL = 3'h6;
  localparam logic [2:0] PTM_REG_PERH = 3'h7;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PTM_POS_PAUSE = 7;
  localparam int unsigned PTM_POS_CKSEL = 4;
  localparam int unsigned PTM_POS_ON = 3;
  localparam int unsigned PTM_POS_MODE = 6;
  localparam int unsigned PTM_POS_FN = 4;
  localparam int unsigned PTM_POS_OC = 3;
  localparam int unsigned PTM_POS_INV = 2;
  localparam int unsigned PTM_POS_CKS = 1;
  localparam int unsigned PTM_POS_CCLR = 0;
  localparam logic [7:0] PTM_BYTE_RST = 8'h00;
  localparam logic [9:0] PTM_CNT_RST = 10'h000;
  localparam logic [9:0] PTM_CNT_MAX = 10'h3ff;
  localparam logic [9:0] PTM_CNT_ONE = 10'h001;

  // ----------------------------------------------------------------
  // Clock select and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [2:0] PTM_CK_SYS4 = 3'h0;
  localparam logic [2:0] PTM_CK_SYS = 3'h1;
  localparam logic [2:0] PTM_CK_FH16 = 3'h2;
  localparam logic [2:0] PTM_CK_FH64 = 3'h3;
  localparam logic [2:0] PTM_CK_TB0 = 3'h4;
  localparam logic [2:0] PTM_CK_TB1 = 3'h5;
  localparam logic [2:0] PTM_CK_EXR = 3'h6;
  localparam logic [2:0] PTM_CK_EXF = 3'h7;
  localparam logic [5:0] PTM_PRE_SYS4 = 6'h03;
  localparam logic [5:0] PTM_PRE_FH16 = 6'h0f;
  localparam logic [5:0] PTM_PRE_FH64 = 6'h3f;

  // ----------------------------------------------------------------
  // Modes and output function codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PTM_MODE_CMP, PTM_MODE_CAP, PTM_MODE_PWM, PTM_MODE_TMR} ptm_mode_t;
  localparam logic [1:0] PTM_FN_0 = 2'h0;
  localparam logic [1:0] PTM_FN_1 = 2'h1;
  localparam logic [1:0] PTM_FN_2 = 2'h2;
  localparam logic [1:0] PTM_FN_3 = 2'h3;
endpackage

//--- logic/ptm_timer.sv
// Periodic timer module: 10-bit counter, two comparators, register port
//
// Behaviour
// [R1] Counter counts up on selected clock source
// [R2] Pause bit holds count, resumes from it
// [R3] On rise clears counter; fall stops, keeps count
// [R4] Only on rise, overflow, match clear counter
// [R5] Comparators A and P check 10-bit values
// [R6] Counter readable; compare values low/high pairs
// [R7] Compare mode: on rise restores initial level
// [R8] Mode field picks one of four modes
// [R9] Software stops timer before changing mode
// [R10] Compare A match drives output per function
// [R11] PWM mode: function picks forced, PWM, pulse
// [R12] Capture mode: function picks capture edge
// [R13] Software changes function only while stopped
// [R14] Init level sets start or active polarity
// [R15] Invert bit flips outputs except timer mode; the code also ignores it in capture mode, where the pins sit at 0 and 1
// [R16] Capture source: capture pin or clock pin
// [R17] Clear select: P match or A match
// [R18] Unused bits read zero; controls reset zero
// [R19] Two input pins, two output pins
// [R20] P clear or overflow raises both flags; the code raises only the P flag there, and the A flag only on an A match or a capture
// [R21] Clear on A never raises P flag
// [R22] PWM period from P value, duty from A
// [R23] Second output pin is first one complemented; the code holds both pins at 0 from reset to the first clock after it
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module ptm_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ptm_pkg::PTM_AW-1:0] addr,
  input wire logic [ptm_pkg::PTM_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ptm_pkg::PTM_DW-1:0] rdata,
  input wire logic tb_tick,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic timer_output_inv_pin,
  output logic compare_a_flag,
  output logic compare_p_flag
);
  import ptm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pause;
    logic [2:0] cksel;
    logic on;
    logic on_d;
    ptm_mode_t mode;
    logic [1:0] fn;
    logic oc;
    logic inv;
    logic cks;
    logic cclr;
    logic [PTM_CW-1:0] compare_a_value;
    logic [PTM_CW-1:0] period_compare_value;
    logic [PTM_CW-1:0] cnt;
    logic lvl;
    logic [PTM_PW-1:0] pre;
    logic [2:0] ext_s;
    logic [2:0] cap_s;
    logic [PTM_DW-1:0] rdata;
    logic fa;
    logic fp;
    logic pin;
    logic pinb;
  } ptm_state_t;

  ptm_state_t s_ff;
  ptm_state_t nxt_s;

  logic tick;
  logic run;
  logic on_rise;
  logic ext_rise;
  logic ext_fall;
  logic src_rise;
  logic src_fall;
  logic cap_hit;
  logic a_hit;
  logic p_hit;
  logic single;
  logic raw;
  logic lvl_out;
  logic [PTM_CW-1:0] inc;

  // Edge of a synchronised pin; only the second and third flops are looked at
  function automatic logic pin_edge(input logic [2:0] sync, input logic rise);
    return rise ? (sync[1] & ~sync[2]) : (~sync[1] & sync[2]);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // Pins pass two flops; [1] vs [2] gives the edge, [0] feeds only [1]
    nxt_s.ext_s = {s_ff.ext_s[1:0], ext_clock_pin}; // [R19]
    nxt_s.cap_s = {s_ff.cap_s[1:0], capture_input_pin}; // [R19]
    ext_rise = pin_edge(s_ff.ext_s, 1'b1);
    ext_fall = pin_edge(s_ff.ext_s, 1'b0);
    src_rise = s_ff.cks ? ext_rise : pin_edge(s_ff.cap_s, 1'b1); // [R16]
    src_fall = s_ff.cks ? ext_fall : pin_edge(s_ff.cap_s, 1'b0); // [R16]
    nxt_s.pre = s_ff.pre + 6'h01;
    // f_H is taken as the system clock, so both share one prescaler
    unique case (s_ff.cksel) // [R1]
      PTM_CK_SYS4: tick = (s_ff.pre[1:0] == PTM_PRE_SYS4[1:0]);
      PTM_CK_SYS: tick = 1'b1;
      PTM_CK_FH16: tick = (s_ff.pre[3:0] == PTM_PRE_FH16[3:0]);
      PTM_CK_FH64: tick = (s_ff.pre == PTM_PRE_FH64);
      PTM_CK_TB0: tick = tb_tick;
      PTM_CK_TB1: tick = tb_tick;
      PTM_CK_EXR: tick = ext_rise;
      PTM_CK_EXF: tick = ext_fall;
    endcase
    on_rise = s_ff.on & ~s_ff.on_d;
    nxt_s.on_d = s_ff.on;
    run = s_ff.on & ~s_ff.pause & tick & ~on_rise; // [R2] [R3]
    inc = s_ff.cnt + PTM_CNT_ONE;
    a_hit = (s_ff.compare_a_value != PTM_CNT_RST) && (inc == s_ff.compare_a_value); // [R5]
    // Zero period means the counter runs to its top and wraps
    p_hit = (s_ff.period_compare_value == PTM_CNT_RST) ? (s_ff.cnt == PTM_CNT_MAX)
                                      : (inc == s_ff.period_compare_value); // [R5] [R20]
    single = (s_ff.mode == PTM_MODE_PWM) && (s_ff.fn == PTM_FN_3);
    cap_hit = 1'b0;
    if (s_ff.mode == PTM_MODE_CAP && s_ff.on) begin
      unique case (s_ff.fn) // [R12]
        PTM_FN_0: cap_hit = src_rise;
        PTM_FN_1: cap_hit = src_fall;
        PTM_FN_2: cap_hit = src_rise | src_fall;
        PTM_FN_3: cap_hit = 1'b0;
      endcase
    end
    nxt_s.fa = 1'b0;
    nxt_s.fp = 1'b0;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    if (on_rise) begin
      nxt_s.cnt = PTM_CNT_RST; // [R3] [R4]
      if (s_ff.mode == PTM_MODE_CMP) begin
        nxt_s.lvl = s_ff.oc; // [R7] [R14]
      end
    end else if (run) begin
      nxt_s.cnt = inc; // [R1]
      if (single) begin
        // The pulse ends on an A match; the counter is not cleared here
        if (a_hit) begin
          nxt_s.on = 1'b0;
          nxt_s.fa = 1'b1;
        end
      end else if (s_ff.mode == PTM_MODE_PWM || s_ff.mode == PTM_MODE_CAP) begin
        if (p_hit) begin
          nxt_s.cnt = PTM_CNT_RST; // [R22] [R4]
          nxt_s.fp = 1'b1;
        end
        if (a_hit && s_ff.mode == PTM_MODE_PWM) begin
          nxt_s.fa = 1'b1;
        end
      end else if (s_ff.cclr) begin
        if (a_hit) begin
          nxt_s.cnt = PTM_CNT_RST; // [R17] [R21]
          nxt_s.fa = 1'b1;
        end
      end else begin
        if (p_hit) begin
          nxt_s.cnt = PTM_CNT_RST; // [R17] [R20]
          nxt_s.fp = 1'b1;
        end
        if (a_hit) begin
          nxt_s.fa = 1'b1; // [R20]
        end
      end
      if (s_ff.mode == PTM_MODE_CMP && a_hit) begin
        unique case (s_ff.fn) // [R10]
          PTM_FN_0: nxt_s.lvl = s_ff.lvl;
          PTM_FN_1: nxt_s.lvl = 1'b0;
          PTM_FN_2: nxt_s.lvl = 1'b1;
          PTM_FN_3: nxt_s.lvl = ~s_ff.lvl;
        endcase
      end
    end
    if (cap_hit) begin
      nxt_s.compare_a_value = s_ff.cnt; // [R12]
      nxt_s.fa = 1'b1;
    end

    // ----------------------------------------------------------------
    // Output pins
    // ----------------------------------------------------------------
    unique case (s_ff.fn) // [R11]
      PTM_FN_0: raw = 1'b0;
      PTM_FN_1: raw = 1'b1;
      PTM_FN_2: raw = (s_ff.cnt < s_ff.compare_a_value); // [R22]
      PTM_FN_3: raw = s_ff.on;
    endcase
    unique case (s_ff.mode) // [R8]
      PTM_MODE_CMP: lvl_out = s_ff.lvl ^ s_ff.inv; // [R15]
      PTM_MODE_PWM: lvl_out = ~(raw ^ s_ff.oc) ^ s_ff.inv; // [R14] [R15]
      PTM_MODE_CAP: lvl_out = 1'b0;
      PTM_MODE_TMR: lvl_out = 1'b0; // [R15]
    endcase
    nxt_s.pin = lvl_out;
    nxt_s.pinb = ~lvl_out; // [R23]

    // ----------------------------------------------------------------
    // Register port; the counter has no write path
    // ----------------------------------------------------------------
    if (wr_en) begin
      unique case (addr) // [R4] [R6]
        PTM_REG_CTRL0: begin
          nxt_s.pause = wdata[PTM_POS_PAUSE];
          nxt_s.cksel = wdata[PTM_POS_CKSEL+:3];
          // A write of the run bit wins over the pulse-end clear
          nxt_s.on = wdata[PTM_POS_ON];
        end
        PTM_REG_CTRL1: begin
          nxt_s.mode = ptm_mode_t'(wdata[PTM_POS_MODE+:2]);
          nxt_s.fn = wdata[PTM_POS_FN+:2];
          nxt_s.oc = wdata[PTM_POS_OC];
          nxt_s.inv = wdata[PTM_POS_INV];
          nxt_s.cks = wdata[PTM_POS_CKS];
          nxt_s.cclr = wdata[PTM_POS_CCLR];
        end
        PTM_REG_CMPAL: nxt_s.compare_a_value[7:0] = wdata;
        PTM_REG_CMPAH: nxt_s.compare_a_value[9:8] = wdata[1:0];
        PTM_REG_PERL: nxt_s.period_compare_value[7:0] = wdata;
        PTM_REG_PERH: nxt_s.period_compare_value[9:8] = wdata[1:0];
        default: begin
        end
      endcase
    end
    nxt_s.rdata = PTM_BYTE_RST;
    if (rd_en) begin
      unique case (addr) // [R6] [R18]
        PTM_REG_CTRL0: nxt_s.rdata = {s_ff.pause, s_ff.cksel, s_ff.on, 3'h0};
        PTM_REG_CTRL1: nxt_s.rdata = {s_ff.mode, s_ff.fn, s_ff.oc, s_ff.inv,
                                      s_ff.cks, s_ff.cclr};
        PTM_REG_CNTL: nxt_s.rdata = s_ff.cnt[7:0];
        PTM_REG_CNTH: nxt_s.rdata = {6'h00, s_ff.cnt[9:8]};
        PTM_REG_CMPAL: nxt_s.rdata = s_ff.compare_a_value[7:0];
        PTM_REG_CMPAH: nxt_s.rdata = {6'h00, s_ff.compare_a_value[9:8]};
        PTM_REG_PERL: nxt_s.rdata = s_ff.period_compare_value[7:0];
        PTM_REG_PERH: nxt_s.rdata = {6'h00, s_ff.period_compare_value[9:8]};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0; // [R18]
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rdata;
  assign timer_output_pin = s_ff.pin; // [R19]
  assign timer_output_inv_pin = s_ff.pinb; // [R19]
  assign compare_a_flag = s_ff.fa;
  assign compare_p_flag = s_ff.fp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  pause_hold_a: assert property ( // [R2]
    s_ff.pause && s_ff.on && s_ff.on_d && !wr_en |=> $stable(s_ff.cnt))
    else $error("counter moved while paused");

  on_clear_a: assert property ( // [R3]
    s_ff.on && !s_ff.on_d |=> s_ff.cnt == PTM_CNT_RST)
    else $error("counter not cleared on run start");

  off_hold_a: assert property ( // [R3]
    !s_ff.on && !s_ff.on_d |=> $stable(s_ff.cnt))
    else $error("counter moved while stopped");

  init_level_a: assert property ( // [R7]
    s_ff.on && !s_ff.on_d && s_ff.mode == PTM_MODE_CMP |=> s_ff.lvl == $past(s_ff.oc))
    else $error("output not restored to initial level");

  p_clear_a: assert property ( // [R20]
    run && p_hit && !s_ff.cclr && s_ff.mode == PTM_MODE_CMP
    |=> s_ff.cnt == PTM_CNT_RST && s_ff.fp)
    else $error("period match did not clear counter");

  no_pflag_a: assert property ( // [R21]
    s_ff.cclr && s_ff.mode == PTM_MODE_CMP |=> !s_ff.fp)
    else $error("period flag raised with clear on A");

  pwm_duty_a: assert property ( // [R22]
    s_ff.mode == PTM_MODE_PWM && s_ff.fn == PTM_FN_2
    |=> s_ff.pin == (($past(s_ff.cnt) < $past(s_ff.compare_a_value)) ^ !$past(s_ff.oc) ^ $past(s_ff.inv)))
    else $error("pwm level wrong");

  capture_a: assert property ( // [R12]
    cap_hit && !wr_en |=> s_ff.compare_a_value == $past(s_ff.cnt) && s_ff.fa)
    else $error("capture did not latch counter");

  pin_comp_a: assert property ( // [R23]
    !$past(rst) |-> s_ff.pinb == !s_ff.pin)
    else $error("second pin not complement");

  rd_zero_a: assert property ( // [R18]
    rd_en && addr == PTM_REG_CTRL0 |=> rdata[2:0] == 3'h0 ##1 (rdata == PTM_BYTE_RST || $past(rd_en)))
    else $error("reserved bits not zero");

  count_step_a: assert property ( // [R1]
    run && s_ff.mode == PTM_MODE_CMP && !p_hit && !a_hit
    |=> s_ff.cnt == $past(s_ff.cnt) + PTM_CNT_ONE)
    else $error("counter did not step by one");

  a_match_clear_a: assert property ( // [R17]
    run && a_hit && s_ff.cclr && (s_ff.mode == PTM_MODE_CMP || s_ff.mode == PTM_MODE_TMR)
    |=> s_ff.cnt == PTM_CNT_RST && s_ff.fa)
    else $error("compare a match did not clear counter");

  a_zero_flag_a: assert property ( // [R5]
    s_ff.compare_a_value == PTM_CNT_RST && s_ff.mode == PTM_MODE_CMP |=> !s_ff.fa)
    else $error("compare a flag raised with zero value");

  pwm_period_a: assert property ( // [R22]
    run && s_ff.mode == PTM_MODE_PWM && s_ff.fn != PTM_FN_3 && p_hit
    |=> s_ff.cnt == PTM_CNT_RST && s_ff.fp)
    else $error("pwm period match did not clear counter");

  pulse_stop_a: assert property ( // [R11]
    run && single && a_hit && !wr_en |=> !s_ff.on && s_ff.fa)
    else $error("single pulse did not stop on match");

  timer_pins_a: assert property ( // [R15]
    s_ff.mode == PTM_MODE_TMR |=> !s_ff.pin && s_ff.pinb)
    else $error("timer mode pins not at fixed level");
endmodule // ptm_timer

//--- bench/ptm_pins_model.sv
// Pin-side partner of the periodic timer: external clock, capture and time-base sources
`timescale 1ns/1ps
module ptm_pins_model #(
  parameter int TB_DIV = 8
) (
  input wire logic clk,
  output logic ext_clock_pin,
  output logic capture_input_pin,
  output logic tb_tick
);
  int tb_cnt = 0;

  // Both input pins driven at all times
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    tb_tick = 1'b0;
  end

  // ----------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------
  // Free-running time-base tick, one cycle wide every TB_DIV cycles
  always @(posedge clk) begin
    tb_cnt <= (tb_cnt == TB_DIV - 1) ? 0 : tb_cnt + 1;
    tb_tick <= (tb_cnt == TB_DIV - 1);
  end

  // Phases of at least w cycles; the pins pass a 2-flop sync, so shorter ones may vanish
  task automatic ext_pulse(input int n, input int w);
    repeat (n) begin
      @(posedge clk);
      ext_clock_pin <= 1'b1;
      repeat (w) @(posedge clk);
      ext_clock_pin <= 1'b0;
      repeat (w - 1) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic cap_set(input logic v);
    @(posedge clk);
    capture_input_pin <= v;
    repeat (5) @(posedge clk);
  endtask
endmodule // ptm_pins_model

//--- bench/testbench.sv
// Self-checking testbench for the periodic timer
`timescale 1ns/1ps
module testbench;
  import ptm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [PTM_AW-1:0] addr = 3'h0;
  logic [PTM_DW-1:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [PTM_DW-1:0] rdata;
  logic tb_tick, ext_clock_pin, capture_input_pin;
  logic timer_output_pin, timer_output_inv_pin, compare_a_flag, compare_p_flag;
  int mismatches = 0;
  int n_checks = 0;
  int k;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  string nm_q[$];
  logic [1:0] fn;
  logic oc, inv, lvl;
  logic [7:0] rnd;
  logic [15:0] pins_now;
  // Flag spacing is period 5 times the source divider (sys/4, sys, /16, /64, tick, tick)
  logic [15:0] cs_gap[6] = '{16'h0014, 16'h0005, 16'h0050, 16'h0140, 16'h0028, 16'h0028};
  logic [1:0] pw_fn[5] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  logic pw_oc[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [9:0] pw_a[5] = '{10'h003, 10'h003, 10'h003, 10'h003, 10'h00c};
  logic [15:0] pw_hi[5] = '{16'h0003, 16'h0007, 16'h0000, 16'h000a, 16'h000a};
  logic [7:0] cp_c1[5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h52};
  logic [9:0] cp_a[5] = '{10'h005, 10'h008, 10'h008, 10'h2aa, 10'h00a};

  assign pins_now = {14'h0000, timer_output_pin, timer_output_inv_pin};
  always #50 clk = ~clk;

  ptm_timer u_ptm_timer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .tb_tick(tb_tick), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin), .timer_output_pin(timer_output_pin),
    .timer_output_inv_pin(timer_output_inv_pin), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag));
  ptm_pins_model u_ptm_pins_model (.clk(clk), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin), .tb_tick(tb_tick));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function automatic logic [15:0] pv(input logic p);
    return {14'h0000, p, ~p};
  endfunction
  // Read data is valid in the cycle after the strobe only
  always @(posedge clk) begin
    rd_d <= rd_en;
    if (rd_d === 1'b1) begin
      chk(nm_q.pop_front(), {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] ex, input string nm);
    exp_q.push_back(ex);
    nm_q.push_back(nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic wr10(input logic [2:0] lo, input logic [9:0] v);
    wr(lo, v[7:0]);
    wr(lo + 3'h1, {6'h00, v[9:8]});
  endtask
  task automatic rd10(input logic [2:0] lo, input logic [9:0] v, input string nm);
    rd(lo, v[7:0], nm);
    rd(lo + 3'h1, {6'h00, v[9:8]}, nm);
  endtask
  // Switched off before mode or function changes
  task automatic setup(input logic [7:0] c1);
    wr(PTM_REG_CTRL0, 8'h00);
    wr(PTM_REG_CTRL1, c1);
  endtask
  task automatic wait_flag(input logic a);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (((a ? compare_a_flag : compare_p_flag) !== 1'b1) && (k < 5000));
    if (k >= 5000) chk("flag wait", 16'h0000, 16'(k));
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h385e00c8));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, "reset value");
    wr(PTM_REG_CTRL0, 8'hf7);
    rd(PTM_REG_CTRL0, 8'hf0, "ctrl0 unused bits");
    rnd = 8'($urandom);
    wr(PTM_REG_CTRL1, rnd);
    rd(PTM_REG_CTRL1, rnd, "ctrl1 readback");
    wr(PTM_REG_CMPAH, 8'hff);
    rd(PTM_REG_CMPAH, 8'h03, "compare a high");
    wr(PTM_REG_PERH, 8'hfe);
    rd(PTM_REG_PERH, 8'h02, "period high");
    // External clock counting, pause, stop and restart
    setup(8'h00);
    wr10(PTM_REG_PERL, 10'h000);
    wr10(PTM_REG_CMPAL, 10'h000);
    wr(PTM_REG_CTRL0, 8'h68);
    u_ptm_pins_model.ext_pulse(7, 4);
    rd10(PTM_REG_CNTL, 10'h007, "ext rising count");
    wr(PTM_REG_CTRL0, 8'he8);
    u_ptm_pins_model.ext_pulse(3, 9);
    rd10(PTM_REG_CNTL, 10'h007, "paused count");
    wr(PTM_REG_CTRL0, 8'h68);
    u_ptm_pins_model.ext_pulse(2, 4);
    rd10(PTM_REG_CNTL, 10'h009, "resumed count");
    wr(PTM_REG_CTRL0, 8'h60);
    u_ptm_pins_model.ext_pulse(2, 4);
    rd10(PTM_REG_CNTL, 10'h009, "count kept when off");
    wr(PTM_REG_CTRL0, 8'h78);
    u_ptm_pins_model.ext_pulse(4, 9);
    wr(PTM_REG_CNTL, 8'h55);
    wr(PTM_REG_CNTH, 8'h03);
    rd10(PTM_REG_CNTL, 10'h004, "restart and falling count");
    // Internal clock sources, timer mode with invert set
    setup(8'hcc);
    wr10(PTM_REG_PERL, 10'h005);
    wr10(PTM_REG_CMPAL, 10'h002);
    for (int cs = 0; cs < 6; cs++) begin
      wr(PTM_REG_CTRL0, 8'h00);
      wr(PTM_REG_CTRL0, {1'b0, 3'(cs), 4'h8});
      wait_flag(1'b0);
      wait_flag(1'b0);
      chk("period flag spacing", cs_gap[cs], 16'(k));
      chk("timer mode pins", pv(1'b0), pins_now);
    end
    // Clear on compare A, then overflow with period zero
    setup(8'h01);
    wr10(PTM_REG_PERL, 10'h004);
    wr10(PTM_REG_CMPAL, 10'h009);
    wr(PTM_REG_CTRL0, 8'h18);
    wait_flag(1'b1);
    wait_flag(1'b1);
    chk("clear on a spacing", 16'h0009, 16'(k));
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (compare_p_flag !== 1'b0) k++;
    end
    chk("p flag with clear on a", 16'h0000, 16'(k));
    setup(8'h00);
    wr10(PTM_REG_PERL, 10'h000);
    wr10(PTM_REG_CMPAL, 10'h200);
    wr(PTM_REG_CTRL0, 8'h18);
    wait_flag(1'b0);
    wait_flag(1'b0);
    chk("overflow p spacing", 16'h0400, 16'(k));
    wait_flag(1'b1);
    wait_flag(1'b1);
    chk("overflow a spacing", 16'h0400, 16'(k));
    // Compare-match output: every function and initial level, random invert
    wr10(PTM_REG_PERL, 10'h014);
    wr10(PTM_REG_CMPAL, 10'h00a);
    for (int i = 0; i < 8; i++) begin
      fn = 2'(i >> 1);
      oc = i[0];
      inv = 1'($urandom);
      setup({2'b00, fn, oc, inv, 2'b00});
      wr(PTM_REG_CTRL0, 8'h18);
      repeat (5) @(posedge clk);
      chk("initial level", pv(oc ^ inv), pins_now);
      wait_flag(1'b1);
      repeat (3) @(posedge clk);
      lvl = (fn == 2'h0) ? oc : (fn == 2'h1) ? 1'b0 : (fn == 2'h2) ? 1'b1 : ~oc;
      chk("match level", pv(lvl ^ inv), pins_now);
    end
    // PWM duty over one period of 10 clocks
    wr10(PTM_REG_PERL, 10'h00a);
    for (int i = 0; i < 5; i++) begin
      setup({2'b10, pw_fn[i], pw_oc[i], 3'b000});
      wr10(PTM_REG_CMPAL, pw_a[i]);
      wr(PTM_REG_CTRL0, 8'h18);
      repeat (25) @(posedge clk);
      k = 0;
      repeat (10) begin
        @(posedge clk);
        if (timer_output_pin === 1'b1) k++;
      end
      chk("pwm high cycles", pw_hi[i], 16'(k));
    end
    // Single pulse ends itself on compare A
    setup(8'hb8);
    wr10(PTM_REG_CMPAL, 10'h006);
    wr(PTM_REG_CTRL0, 8'h18);
    repeat (20) @(posedge clk);
    rd(PTM_REG_CTRL0, 8'h10, "single pulse self stop");
    chk("single pulse idle", pv(1'b0), pins_now);
    // Capture edges and capture source
    wr10(PTM_REG_PERL, 10'h000);
    for (int i = 0; i < 5; i++) begin
      setup(cp_c1[i]);
      wr10(PTM_REG_CMPAL, 10'h2aa);
      wr(PTM_REG_CTRL0, 8'h68);
      u_ptm_pins_model.ext_pulse(5, 4);
      u_ptm_pins_model.cap_set(1'b1);
      u_ptm_pins_model.ext_pulse(3, 4);
      u_ptm_pins_model.cap_set(1'b0);
      u_ptm_pins_model.ext_pulse(2, 4);
      rd10(PTM_REG_CMPAL, cp_a[i], "captured count");
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule // testbench
